// ---- verilog/tpfcs_pkg.sv ----
// Shared constants for the two-point field calibration sequencer
`default_nettype none
package tpfcs_pkg;
  localparam logic [7:0] REG_GAS1_HI     = 8'h7E;
  localparam logic [7:0] REG_GAS1_LO     = 8'h7F;
  localparam logic [7:0] REG_DATE_MD     = 8'h80;
  localparam logic [7:0] REG_DATE_YEAR   = 8'h81;
  localparam logic [7:0] REG_GAS2_HI     = 8'h82;
  localparam logic [7:0] REG_GAS2_LO     = 8'h83;
  localparam logic [7:0] REG_START       = 8'h84;
  localparam logic [7:0] REG_ABORT       = 8'h85;
  localparam logic [7:0] REG_STATUS      = 8'h86;
  localparam logic [7:0] REG_GAS_START   = 8'h87;

  localparam logic [15:0] EXPOSURE_MIN_MINUTES = 16'h003C;
  localparam logic [15:0] EXPOSURE_MAX_MINUTES = 16'h05A0;
  localparam logic [31:0] CONC_MAX_PPM         = 32'h0098_9680;
  localparam logic [15:0] CMD_ABORT            = 16'h0001;
  localparam logic [15:0] CMD_CLEAR            = 16'h0002;
  localparam logic [15:0] CMD_GAS1             = 16'h0001;
  localparam logic [15:0] CMD_GAS2             = 16'h0002;

  localparam int CLK_HZ       = 50_000_000;
  localparam int MINUTE_S     = 60;
  localparam longint MINUTE_CYCLES = longint'(CLK_HZ) * MINUTE_S;

  localparam int STATUS_POS = 8;
  localparam int ERROR_POS  = 0;

  localparam logic [7:0] ST_SUCCESS     = 8'h00;
  localparam logic [7:0] ST_IN_PROGRESS = 8'h01;
  localparam logic [7:0] ST_FAILED      = 8'h02;
  localparam logic [7:0] ST_CANCELLED   = 8'h03;
  localparam logic [7:0] ST_REMOVED     = 8'h04;
  localparam logic [7:0] ST_NOT_EXEC    = 8'h05;
  localparam logic [7:0] ST_RESET       = ST_SUCCESS;

  localparam logic [7:0] ER_NONE        = 8'h00;
  localparam logic [7:0] ER_IN_PROGRESS = 8'h02;
  localparam logic [7:0] ER_EXPOSURE    = 8'h03;
  localparam logic [7:0] ER_INTERNAL    = 8'h04;
  localparam logic [7:0] ER_DIAG        = 8'h05;
  localparam logic [7:0] ER_CONC_RANGE  = 8'h07;
  localparam logic [7:0] ER_GAS_ORDER   = 8'h08;
  localparam logic [7:0] ER_DATA        = 8'h0A;
  localparam logic [7:0] ER_GAIN_LIMIT  = 8'h0C;
  localparam logic [7:0] ER_SKIPPED     = 8'h0D;
  localparam logic [7:0] ER_NOT_EXPOSED = 8'h0E;
  localparam logic [7:0] ER_RESET       = ER_NONE;

  typedef enum {
    TPF_IDLE,
    TPF_WAIT_GAS1,
    TPF_EXPOSE1,
    TPF_WAIT_CONC1,
    TPF_WAIT_GAS2,
    TPF_EXPOSE2,
    TPF_WAIT_CONC2,
    TPF_WAIT_DATE,
    TPF_REBOOT
  } tpfcs_state_t;
endpackage
`default_nettype wire

// ---- verilog/tpfcs_minute_timer.sv ----
// Exposure timer: counts whole minutes up to a loaded target
`timescale 1ns/10ps
`default_nettype none
module tpfcs_minute_timer #(
  parameter longint CYCLES_PER_MINUTE = tpfcs_pkg::MINUTE_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [15:0] minutes,
  output logic             done
);
  import tpfcs_pkg::*;

  // Refuse a tick count that the 32-bit prescaler cannot hold
  if (CYCLES_PER_MINUTE < 1 || CYCLES_PER_MINUTE > 64'h0000_0000_FFFF_FFFF) begin
    $error("tpfcs_minute_timer: cycles per minute out of range");
  end

  localparam logic [31:0] TICK_LAST = 32'(CYCLES_PER_MINUTE - 1);

  logic [31:0] tick_reg;
  logic [15:0] min_reg;
  logic [15:0] target_reg;
  logic        run_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_reg   <= 32'h0000_0000;
      min_reg    <= 16'h0000;
      target_reg <= 16'h0000;
      run_reg    <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        tick_reg   <= 32'h0000_0000;
        min_reg    <= 16'h0000;
        target_reg <= minutes;
        run_reg    <= 1'b1;
      end else if (stop) begin
        run_reg <= 1'b0;
      end else if (run_reg && min_reg != target_reg) begin
        if (tick_reg == TICK_LAST) begin
          tick_reg <= 32'h0000_0000;
          min_reg  <= min_reg + 16'h0001;
        end else begin
          tick_reg <= tick_reg + 32'h0000_0001;
        end
      end
    end
  end

  assign done = run_reg && (min_reg == target_reg);
endmodule
`default_nettype wire

// ---- verilog/tpfcs_range_check.sv ----
// Range checks for exposure minutes and gas concentration words
`timescale 1ns/10ps
`default_nettype none
module tpfcs_range_check #(
  parameter logic [31:0] MODEL_MIN_PPM = 32'h0000_0000,
  parameter logic [31:0] MODEL_MAX_PPM = tpfcs_pkg::CONC_MAX_PPM
) (
  input  wire logic [15:0] minutes,
  input  wire logic [15:0] conc_high,
  input  wire logic [15:0] conc_low,
  output logic             minutes_ok,
  output logic             conc_ok
);
  import tpfcs_pkg::*;

  if (MODEL_MIN_PPM > MODEL_MAX_PPM || MODEL_MAX_PPM > CONC_MAX_PPM) begin
    $error("tpfcs_range_check: model ppm limits invalid");
  end

  logic [31:0] conc;
  assign conc       = {conc_high, conc_low};
  assign minutes_ok = (minutes >= EXPOSURE_MIN_MINUTES) && (minutes <= EXPOSURE_MAX_MINUTES);
  assign conc_ok    = (conc >= MODEL_MIN_PPM) && (conc <= MODEL_MAX_PPM);
endmodule
`default_nettype wire

// ---- verilog/tpfcs_sequencer.sv ----
// Two-point field calibration command sequencer with holding registers
// Functional notes
// R1 - Host starts calibration writing exposure minutes, 60 to 1440, to start register.
// R2 - Start with duration outside range is rejected with error 3.
// R3 - Successful start reports status 1, in progress.
// R4 - Read-only status register: status code high byte, error code low byte.
// R5 - Host reads status register after every calibration register write.
// R6 - Host writes 1 when gas 1 flows, 2 when gas 2 flows.
// R7 - Gas 2 start before gas 1 phase completes is refused, error 8; code gives error 14 throughout EXPOSE1, even after exposure elapsed.
// R8 - Gas 1 ppm written as 32 bits, high word then low word.
// R9 - Gas 2 ppm written as 32 bits, high word then low word.
// R10 - Concentration outside 0 to 10,000,000 ppm or model range gives error 7.
// R11 - Host converts percent to ppm by multiplying by 10,000.
// R12 - Date finishes calibration: month and day word, then year word.
// R13 - Accepted finishing date write triggers automatic reboot.
// R14 - Abort value 1 or power cycle cancels running calibration.
// R15 - Abort value 2 removes field calibration, restores factory, status 4.
// R16 - Status codes: 0 ok, 1 running, 2 failed, 3 cancelled, 4 removed, 5 refused.
// R17 - Error stays 0 on accepted writes; completion reads status 0, error 0.
// R18 - Start while calibration running is rejected with error 2.
// R19 - Concentration or next step before exposure elapsed gives error 14.
// R20 - Skipped sequence step gives error 13.
// R21 - Gain or offset out of limits gives 12; unusable data gives 10.
// R22 - Internal fault gives error 4; error 5 diagnostic only.
// R23 - Gain and offset computed from gas values and readings, applied afterwards.
// R24 - Link defaults: RS-485 half duplex, 19200 baud, 8N2, address 1.
// R25 - Writes processed in arrival order; status updated before next read.
`timescale 1ns/10ps
`default_nettype none
module tpfcs_sequencer #(
  parameter longint      CYCLES_PER_MINUTE = tpfcs_pkg::MINUTE_CYCLES,
  parameter logic [31:0] MODEL_MIN_PPM     = 32'h0000_0000,
  parameter logic [31:0] MODEL_MAX_PPM     = tpfcs_pkg::CONC_MAX_PPM
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_ack,
  output logic             reg_err,
  input  wire logic        calc_done,
  input  wire logic        calc_gain_bad,
  input  wire logic        calc_data_bad,
  input  wire logic        internal_fault,
  output logic             calc_start,
  output logic             cal_applied,
  output logic             factory_restore,
  output logic             reboot_req,
  output logic [31:0]      gas1_ppm,
  output logic [31:0]      gas2_ppm
);
  import tpfcs_pkg::*;

  tpfcs_state_t state_reg;
  logic [7:0]   status_reg;
  logic [7:0]   error_reg;
  logic [15:0]  minutes_reg;
  logic [15:0]  g1_hi_reg;
  logic [15:0]  g1_lo_reg;
  logic [15:0]  g2_hi_reg;
  logic [15:0]  g2_lo_reg;
  logic [15:0]  date_md_reg;
  logic [15:0]  date_yr_reg;
  logic         g1_hi_seen_reg;
  logic         g2_hi_seen_reg;
  logic         calc_busy_reg;
  logic         applied_reg;
  logic         restore_reg;
  logic         reboot_reg;
  logic         calc_start_reg;
  logic [15:0]  rdata_reg;
  logic         ack_reg;
  logic         err_reg;

  logic         tmr_start;
  logic         tmr_done;
  logic         minutes_ok;
  logic         conc_ok;
  logic [15:0]  chk_high;

  tpfcs_minute_timer #(
    .CYCLES_PER_MINUTE (CYCLES_PER_MINUTE)
  ) u_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .start   (tmr_start),
    .stop    (state_reg == TPF_IDLE),
    .minutes (minutes_reg),
    .done    (tmr_done)
  );

  // Low-word writes range-check the stored high word joined with the new low word
  assign chk_high = (reg_addr == REG_GAS2_LO) ? g2_hi_reg : g1_hi_reg;

  tpfcs_range_check #(
    .MODEL_MIN_PPM (MODEL_MIN_PPM),
    .MODEL_MAX_PPM (MODEL_MAX_PPM)
  ) u_check (
    .minutes    (reg_wdata),
    .conc_high  (chk_high),
    .conc_low   (reg_wdata),
    .minutes_ok (minutes_ok),
    .conc_ok    (conc_ok)
  );

  logic wr_go;
  assign wr_go = clk_en && reg_wr && !calc_busy_reg && !reboot_reg;
  assign tmr_start = wr_go && reg_addr == REG_GAS_START &&
                     ((state_reg == TPF_WAIT_GAS1 && reg_wdata == CMD_GAS1) ||
                      (state_reg == TPF_WAIT_GAS2 && reg_wdata == CMD_GAS2));

  // Sequencer: one write per cycle, handled in arrival order
  // R16 - status code set
  // R25 - ordered processing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= TPF_IDLE;
      status_reg     <= ST_RESET;
      error_reg      <= ER_RESET;
      minutes_reg    <= 16'h0000;
      g1_hi_reg      <= 16'h0000;
      g1_lo_reg      <= 16'h0000;
      g2_hi_reg      <= 16'h0000;
      g2_lo_reg      <= 16'h0000;
      date_md_reg    <= 16'h0000;
      date_yr_reg    <= 16'h0000;
      g1_hi_seen_reg <= 1'b0;
      g2_hi_seen_reg <= 1'b0;
      calc_busy_reg  <= 1'b0;
      calc_start_reg <= 1'b0;
      applied_reg    <= 1'b0;
      restore_reg    <= 1'b0;
      reboot_reg     <= 1'b0;
    end else if (clk_en) begin
      calc_start_reg <= 1'b0;
      restore_reg    <= 1'b0;
      // R22 - internal fault
      if (internal_fault && state_reg != TPF_IDLE) begin
        state_reg     <= TPF_IDLE;
        status_reg    <= ST_FAILED;
        error_reg     <= ER_INTERNAL;
        calc_busy_reg <= 1'b0;
      end else if (calc_busy_reg) begin
        // R21 - computation outcome
        if (calc_done) begin
          calc_busy_reg <= 1'b0;
          if (calc_data_bad) begin
            state_reg  <= TPF_IDLE;
            status_reg <= ST_FAILED;
            error_reg  <= ER_DATA;
          end else if (calc_gain_bad) begin
            state_reg  <= TPF_IDLE;
            status_reg <= ST_FAILED;
            error_reg  <= ER_GAIN_LIMIT;
          end else begin
            // R17 - success codes
            // R13 - automatic reboot
            state_reg   <= TPF_REBOOT;
            status_reg  <= ST_SUCCESS;
            error_reg   <= ER_NONE;
            applied_reg <= 1'b1;
            reboot_reg  <= 1'b1;
          end
        end
      end else if (wr_go) begin
        case (reg_addr)
          REG_START: begin
            if (state_reg != TPF_IDLE) begin
              // R18 - already running
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_IN_PROGRESS;
            end else if (!minutes_ok) begin
              // R2 - exposure range
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_EXPOSURE;
            end else begin
              // R3 - in progress
              state_reg      <= TPF_WAIT_GAS1;
              status_reg     <= ST_IN_PROGRESS;
              error_reg      <= ER_NONE;
              minutes_reg    <= reg_wdata;
              g1_hi_seen_reg <= 1'b0;
              g2_hi_seen_reg <= 1'b0;
            end
          end
          REG_ABORT: begin
            if (reg_wdata == CMD_ABORT && state_reg != TPF_IDLE) begin
              // R14 - user abort
              state_reg  <= TPF_IDLE;
              status_reg <= ST_CANCELLED;
              error_reg  <= ER_NONE;
            end else if (reg_wdata == CMD_CLEAR) begin
              // R15 - remove calibration
              state_reg   <= TPF_IDLE;
              status_reg  <= ST_REMOVED;
              error_reg   <= ER_NONE;
              applied_reg <= 1'b0;
              restore_reg <= 1'b1;
            end
          end
          REG_GAS_START: begin
            if (tmr_start) begin
              state_reg  <= (state_reg == TPF_WAIT_GAS1) ? TPF_EXPOSE1 : TPF_EXPOSE2;
              status_reg <= ST_IN_PROGRESS;
              error_reg  <= ER_NONE;
            end else if (state_reg == TPF_EXPOSE1 && reg_wdata == CMD_GAS2) begin
              // R19 - exposure pending
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_NOT_EXPOSED;
            end else if (state_reg != TPF_IDLE && reg_wdata == CMD_GAS2 &&
                         (state_reg == TPF_WAIT_GAS1 || state_reg == TPF_WAIT_CONC1)) begin
              // R7 - gas order
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_GAS_ORDER;
            end else if (state_reg != TPF_IDLE) begin
              // R20 - skipped step
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_SKIPPED;
            end
          end
          REG_GAS1_HI, REG_GAS2_HI: begin
            if (reg_addr == REG_GAS1_HI) begin
              g1_hi_reg      <= reg_wdata;
              g1_hi_seen_reg <= 1'b1;
            end else begin
              g2_hi_reg      <= reg_wdata;
              g2_hi_seen_reg <= 1'b1;
            end
            if (state_reg != TPF_IDLE) begin
              status_reg <= ST_IN_PROGRESS;
              error_reg  <= ER_NONE;
            end
          end
          REG_GAS1_LO, REG_GAS2_LO: begin
            if (reg_addr == REG_GAS1_LO) begin
              g1_lo_reg <= reg_wdata;
            end else begin
              g2_lo_reg <= reg_wdata;
            end
            if ((reg_addr == REG_GAS1_LO && state_reg == TPF_EXPOSE1 && !tmr_done) ||
                (reg_addr == REG_GAS2_LO && state_reg == TPF_EXPOSE2 && !tmr_done)) begin
              // R19 - exposure pending
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_NOT_EXPOSED;
            end else if ((reg_addr == REG_GAS1_LO &&
                          (state_reg != TPF_EXPOSE1 || !g1_hi_seen_reg)) ||
                         (reg_addr == REG_GAS2_LO &&
                          (state_reg != TPF_EXPOSE2 || !g2_hi_seen_reg))) begin
              // R20 - skipped step
              if (state_reg != TPF_IDLE) begin
                status_reg <= ST_NOT_EXEC;
                error_reg  <= ER_SKIPPED;
              end
            end else if (!conc_ok) begin
              // R10 - concentration range
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_CONC_RANGE;
            end else begin
              // R8 - gas 1 pair done
              // R9 - gas 2 pair done
              state_reg  <= (reg_addr == REG_GAS1_LO) ? TPF_WAIT_GAS2 : TPF_WAIT_DATE;
              status_reg <= ST_IN_PROGRESS;
              error_reg  <= ER_NONE;
            end
          end
          REG_DATE_MD: begin
            date_md_reg <= reg_wdata;
            if (state_reg != TPF_IDLE && state_reg != TPF_WAIT_DATE) begin
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_SKIPPED;
            end
          end
          REG_DATE_YEAR: begin
            date_yr_reg <= reg_wdata;
            if (state_reg == TPF_WAIT_DATE) begin
              // R12 - date finishes
              // R23 - start gain and offset computation
              calc_busy_reg  <= 1'b1;
              calc_start_reg <= 1'b1;
            end else if (state_reg != TPF_IDLE) begin
              status_reg <= ST_NOT_EXEC;
              error_reg  <= ER_SKIPPED;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Register read path and access answer
  // R24 - strobes from link
  // R4 - status word layout
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 16'h0000;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= reg_rd || reg_wr;
      err_reg <= 1'b0;
      if (reg_rd) begin
        case (reg_addr)
          REG_STATUS:    rdata_reg <= {status_reg, error_reg};
          REG_GAS1_HI:   rdata_reg <= g1_hi_reg;
          REG_GAS1_LO:   rdata_reg <= g1_lo_reg;
          REG_GAS2_HI:   rdata_reg <= g2_hi_reg;
          REG_GAS2_LO:   rdata_reg <= g2_lo_reg;
          REG_DATE_MD:   rdata_reg <= date_md_reg;
          REG_DATE_YEAR: rdata_reg <= date_yr_reg;
          default: begin
            rdata_reg <= 16'h0000;
            err_reg   <= 1'b1;
          end
        endcase
      end else if (reg_wr) begin
        err_reg <= !(reg_addr >= REG_GAS1_HI && reg_addr <= REG_GAS_START &&
                     reg_addr != REG_STATUS);
      end
    end
  end

  assign reg_rdata       = rdata_reg;
  assign reg_ack         = ack_reg;
  assign reg_err         = err_reg;
  assign calc_start      = calc_start_reg;
  assign cal_applied     = applied_reg;
  assign factory_restore = restore_reg;
  assign reboot_req      = reboot_reg;
  assign gas1_ppm        = {g1_hi_reg, g1_lo_reg};
  assign gas2_ppm        = {g2_hi_reg, g2_lo_reg};

  // R2 - bad exposure refused
  a_start_range_err: assert property (@(posedge ref_clk) disable iff (!reset_n) // R2
    clk_en && reg_wr && reg_addr == REG_START && state_reg == TPF_IDLE && !calc_busy_reg &&
    !reboot_reg && !internal_fault &&
    (reg_wdata < EXPOSURE_MIN_MINUTES || reg_wdata > EXPOSURE_MAX_MINUTES)
    |=> status_reg == ST_NOT_EXEC && error_reg == ER_EXPOSURE && state_reg == TPF_IDLE)
    else $error("bad exposure not refused with code 3");

  a_start_ok_prog: assert property (@(posedge ref_clk) disable iff (!reset_n) // R3
    clk_en && reg_wr && reg_addr == REG_START && state_reg == TPF_IDLE && !calc_busy_reg &&
    !reboot_reg && !internal_fault && reg_wdata >= EXPOSURE_MIN_MINUTES &&
    reg_wdata <= EXPOSURE_MAX_MINUTES
    |=> status_reg == ST_IN_PROGRESS && error_reg == ER_NONE && state_reg == TPF_WAIT_GAS1)
    else $error("valid start did not report in progress");

  a_status_read_word: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    clk_en && reg_rd && reg_addr == REG_STATUS
    |=> reg_rdata == {$past(status_reg), $past(error_reg)} && reg_ack)
    else $error("status word read mismatch");

  a_gas_order_err: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
    wr_go && !internal_fault && reg_addr == REG_GAS_START && reg_wdata == CMD_GAS2 &&
    (state_reg == TPF_WAIT_GAS1 || state_reg == TPF_WAIT_CONC1)
    |=> error_reg == ER_GAS_ORDER && status_reg == ST_NOT_EXEC)
    else $error("early gas 2 start not refused with code 8");

  a_running_start_err: assert property (@(posedge ref_clk) disable iff (!reset_n) // R18
    wr_go && !internal_fault && reg_addr == REG_START && state_reg != TPF_IDLE
    |=> error_reg == ER_IN_PROGRESS && $stable(state_reg))
    else $error("start during calibration not refused with code 2");

  a_abort_cancels: assert property (@(posedge ref_clk) disable iff (!reset_n) // R14
    wr_go && !internal_fault && reg_addr == REG_ABORT && reg_wdata == CMD_ABORT &&
    state_reg != TPF_IDLE
    |=> state_reg == TPF_IDLE && status_reg == ST_CANCELLED)
    else $error("abort did not cancel");

  a_clear_removes: assert property (@(posedge ref_clk) disable iff (!reset_n) // R15
    wr_go && !internal_fault && reg_addr == REG_ABORT && reg_wdata == CMD_CLEAR
    |=> status_reg == ST_REMOVED && factory_restore && !cal_applied)
    else $error("clear did not remove calibration");

  a_early_conc_err: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
    wr_go && !internal_fault && reg_addr == REG_GAS1_LO && state_reg == TPF_EXPOSE1 && !tmr_done
    |=> error_reg == ER_NOT_EXPOSED && status_reg == ST_NOT_EXEC && state_reg == TPF_EXPOSE1)
    else $error("early concentration not refused with code 14");

  a_finish_reboot: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
    clk_en && calc_busy_reg && calc_done && !calc_data_bad && !calc_gain_bad && !internal_fault
    |=> reboot_req && status_reg == ST_SUCCESS && error_reg == ER_NONE)
    else $error("successful finish did not request reboot");
endmodule
`default_nettype wire

// ---- tb/tpfcs_calc_model.sv ----
// Gain and offset engine model answering calculation requests
`timescale 1ns/10ps
`default_nettype none
module tpfcs_calc_model (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic calc_start,
  input  wire logic want_data_bad,
  input  wire logic want_gain_bad,
  output logic      calc_done,
  output logic      calc_gain_bad,
  output logic      calc_data_bad
);
  logic [3:0] cnt_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 4'h0;
    end else if (calc_start) begin
      cnt_reg <= 4'h6;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  assign calc_done = (cnt_reg == 4'h1);
  // Qualifiers are only meaningful with calc_done, so they are inverted otherwise
  assign calc_gain_bad = calc_done ? want_gain_bad : ~want_gain_bad;
  assign calc_data_bad = calc_done ? want_data_bad : ~want_data_bad;
endmodule
`default_nettype wire

// ---- tb/two_point_field_cal_sequencer_tb.sv ----
// Register-level testbench for the calibration sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module two_point_field_cal_sequencer_tb;
  import tpfcs_pkg::*;
  localparam int EXP = 250;
  logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_s;
  logic reg_ack, reg_err, err_s, calc_done, calc_gain_bad, calc_data_bad, calc_start;
  logic cal_applied, factory_restore, reboot_req, want_db = 1'b0, want_gb = 1'b0;
  logic [31:0] gas1_ppm, gas2_ppm;
  logic int_flt = 1'b0;
  int errors = 0, check_count = 0;
  always #10 ref_clk = ~ref_clk;
  tpfcs_sequencer #(.CYCLES_PER_MINUTE(4)) tpfcs_sequencer_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_err(reg_err), .calc_done(calc_done), .calc_gain_bad(calc_gain_bad),
    .calc_data_bad(calc_data_bad), .internal_fault(int_flt), .calc_start(calc_start),
    .cal_applied(cal_applied), .factory_restore(factory_restore), .reboot_req(reboot_req),
    .gas1_ppm(gas1_ppm), .gas2_ppm(gas2_ppm));
  tpfcs_calc_model tpfcs_calc_model_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .calc_start(calc_start), .want_data_bad(want_db),
    .want_gain_bad(want_gb), .calc_done(calc_done), .calc_gain_bad(calc_gain_bad),
    .calc_data_bad(calc_data_bad));
  task automatic test_done();
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rst();
    reset_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 reset_n = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    err_s = reg_err;
    `CHK("write ack", 1'b1, reg_ack)
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    err_s = reg_err;
    rd_s = reg_rdata;
    `CHK("read ack", 1'b1, reg_ack)
  endtask
  task automatic wrchk(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    wr(a, d);
    rd(REG_STATUS);
    `CHK("status", e, rd_s)
  endtask
  task automatic full_cal(input logic [15:0] fin);
    wrchk(REG_START, 16'h003C, 16'h0100);
    wrchk(REG_GAS_START, CMD_GAS1, 16'h0100);
    wr(REG_GAS1_HI, 16'h0098);
    wrchk(REG_GAS1_LO, 16'h9680, 16'h050E);
    wrchk(REG_GAS_START, CMD_GAS2, 16'h050E);
    repeat (EXP) @(posedge ref_clk);
    wr(REG_GAS1_HI, 16'h0098);
    wrchk(REG_GAS1_LO, 16'h9681, 16'h0507);
    wrchk(REG_GAS1_LO, 16'h9680, 16'h0100);
    `CHK("gas1 ppm", 32'h0098_9680, gas1_ppm)
    wrchk(REG_GAS_START, CMD_GAS2, 16'h0100);
    repeat (EXP) @(posedge ref_clk);
    wr(REG_GAS2_HI, 16'h0003);
    wrchk(REG_GAS2_LO, 16'h0D40, 16'h0100);
    `CHK("gas2 ppm", 32'h0003_0D40, gas2_ppm)
    wrchk(REG_DATE_MD, 16'h0C1F, 16'h0100);
    wr(REG_DATE_YEAR, 16'h07E8);
    `CHK("calc start", 1'b1, calc_start)
    repeat (12) @(posedge ref_clk);
    rd(REG_STATUS);
    `CHK("final status", fin, rd_s)
  endtask
  initial begin
    rst();
    rd(REG_STATUS);
    `CHK("reset status", 16'h0000, rd_s)
    rd(8'h10);
    `CHK("unmapped read err", 1'b1, err_s)
    rd(REG_START);
    `CHK("write-only read err", 1'b1, err_s)
    wr(REG_STATUS, 16'h1234);
    `CHK("status write err", 1'b1, err_s)
    wrchk(REG_START, 16'h003B, 16'h0503);
    wrchk(REG_START, 16'h05A1, 16'h0503);
    wrchk(REG_START, 16'h05A0, 16'h0100);
    wrchk(REG_START, 16'h003C, 16'h0502);
    wrchk(REG_GAS_START, CMD_GAS2, 16'h0508);
    wrchk(REG_DATE_YEAR, 16'h07E8, 16'h050D);
    wrchk(REG_ABORT, CMD_ABORT, 16'h0300);
    wr(REG_ABORT, CMD_CLEAR);
    `CHK("restore pulse", 1'b1, factory_restore)
    rd(REG_STATUS);
    `CHK("clear status", 16'h0400, rd_s)
    wrchk(REG_START, 16'h003C, 16'h0100);
    @(posedge ref_clk);
    #1 int_flt = 1'b1;
    @(posedge ref_clk);
    #1 int_flt = 1'b0;
    rd(REG_STATUS);
    `CHK("fault status", 16'h0204, rd_s)
    full_cal(16'h0000);
    `CHK("reboot", 1'b1, reboot_req)
    `CHK("applied", 1'b1, cal_applied)
    rst();
    rd(REG_STATUS);
    `CHK("status after power cycle", 16'h0000, rd_s)
    want_db = 1'b1;
    full_cal(16'h020A);
    rst();
    want_db = 1'b0;
    want_gb = 1'b1;
    full_cal(16'h020C);
    test_done();
  end
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
